/* core/pp_pkg.sv */
// Shared constants for the multi-mode parallel port block.
// Assumes a 100 MHz system clock and a host that holds each request until ready.
package pp_pkg;

  // ****************************************************************
  // Register offsets on the host I/O port
  // ****************************************************************
  localparam logic [3:0] PP_OFF_DATA = 4'h0;
  localparam logic [3:0] PP_OFF_STAT = 4'h1;
  localparam logic [3:0] PP_OFF_CTRL = 4'h2;
  localparam logic [3:0] PP_OFF_EPP_ADDR = 4'h3;
  localparam logic [3:0] PP_OFF_EPP_DATA = 4'h4;
  localparam logic [3:0] PP_OFF_FIFO = 4'h8;
  localparam logic [3:0] PP_OFF_CFGB = 4'h9;
  localparam logic [3:0] PP_OFF_XCTRL = 4'ha;
  localparam logic [3:0] PP_OFF_CFGA = 4'hb;

  // ****************************************************************
  // Operating modes held in the extended control register
  // ****************************************************************
  localparam logic [2:0] PP_MODE_STD = 3'h0;
  localparam logic [2:0] PP_MODE_PS2 = 3'h1;
  localparam logic [2:0] PP_MODE_COMPAT = 3'h2;
  localparam logic [2:0] PP_MODE_ECP = 3'h3;
  localparam logic [2:0] PP_MODE_EPP = 3'h4;
  localparam logic [2:0] PP_MODE_TEST = 3'h6;
  localparam logic [2:0] PP_MODE_CFG = 3'h7;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PP_CTRL_STROBE = 0;
  localparam int PP_CTRL_NINIT = 2;
  localparam int PP_CTRL_DIR = 5;
  localparam int PP_STAT_TMO = 0;
  localparam int PP_XCTRL_MODE_LSB = 5;
  localparam int PP_XCTRL_FULL = 1;
  localparam int PP_XCTRL_EMPTY = 0;

  // ****************************************************************
  // Reset values and fixed contents
  // ****************************************************************
  localparam logic [7:0] PP_DATA_RST = 8'h00;
  localparam logic [7:0] PP_CTRL_RST = 8'h04;
  localparam logic [4:0] PP_XCTRL_RST = 5'h00;
  localparam logic [7:0] PP_CFGA_VAL = 8'h10;
  localparam int PP_PWORD = 8;
  localparam int PP_FIFO_DEPTH = 16;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int PP_CLK_NS = 10;
  localparam int PP_WDOG_NS = 10000;
  localparam logic [10:0] PP_WDOG_CYC = 11'(PP_WDOG_NS / PP_CLK_NS);

endpackage

/* core/pp_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous pin inputs; output changes when stages two and three agree.
`timescale 1ns/1ns
module pp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins in, filtered levels out
  input wire logic [W-1:0] in_i,
  output logic [W-1:0] out_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Stage one feeds only stage two, so no logic sees a metastable level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
    end else begin
      s1 <= in_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Per-bit agreement filter
  for (genvar b = 0; b < W; b++) begin : g_filt
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        out_o[b] <= RST_VAL[b];
      end else if (s2[b] == s3[b]) begin
        out_o[b] <= s3[b];
      end
    end
  end
endmodule // pp_sync

/* core/pp_fifo_mem.sv */
// Storage for the shared byte FIFO, read data from a register.
// Assumes the caller keeps the pointers and the fill count.
`timescale 1ns/1ns
module pp_fifo_mem #(
  parameter int W = 8,
  parameter int D = 16,
  parameter int AW = $clog2(D)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Write side
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [W-1:0] wr_data_i,
  // Read side
  input wire logic [AW-1:0] rd_addr_i,
  output logic [W-1:0] rd_data_o
);
  logic [W-1:0] mem [D];

  // Array carries no reset; contents are don't-care until written
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // Head word is refreshed every cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule // pp_fifo_mem

/* core/pp_port.sv */
// Multi-mode parallel port: register file, EPP cycle engine, shared FIFO.
// Assumes a host that holds rd/wr until io_ready_o and pins that are async.
`timescale 1ns/1ns
module pp_port
  import pp_pkg::*;
#(
  parameter int FIFO_DEPTH = PP_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Host I/O port
  input wire logic [3:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_ready_o,
  // Chip-level configuration
  input wire logic [2:0] cfg_irq_sel_i,
  input wire logic [2:0] cfg_dma_sel_i,
  // Port data lines
  input wire logic [7:0] pd_i,
  output logic [7:0] pd_o,
  output logic pd_oe_o,
  // Peripheral inputs
  input wire logic peripheral_handshake_i,
  input wire logic peripheral_interrupt_in_i,
  input wire logic ack_n_i,
  input wire logic perror_i,
  input wire logic select_i,
  input wire logic fault_n_i,
  // Peripheral outputs
  output logic write_indication_line_n_o,
  output logic data_phase_strobe_n_o,
  output logic address_phase_strobe_n_o,
  output logic peripheral_reset_out_n_o,
  output logic peripheral_irq_o,
  output logic peripheral_irq_edge_o
);
  localparam int AW = $clog2(FIFO_DEPTH);

  typedef enum logic [1:0] {PP_ST_IDLE, PP_ST_STROBE, PP_ST_ACK} pp_state_e;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [13:0] pins_f;
  logic hs_f;
  logic int_f;
  logic [7:0] pd_f;
  logic [3:0] stat_f;
  logic int_q;

  pp_sync #(.W(14), .RST_VAL(14'h3fff)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_i({peripheral_handshake_i, peripheral_interrupt_in_i, ack_n_i, perror_i,
           select_i, fault_n_i, pd_i}),
    .out_o(pins_f)
  );
  assign hs_f = pins_f[13];
  assign int_f = pins_f[12];
  assign stat_f = pins_f[11:8];
  assign pd_f = pins_f[7:0];

  // Interrupt passes straight through, edge detected on the filtered level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_q <= 1'b1;
    end else begin
      int_q <= int_f;
    end
  end
  assign peripheral_irq_o = int_f;
  assign peripheral_irq_edge_o = int_f & ~int_q;

  // ****************************************************************
  // Registers and host decode
  // ****************************************************************
  pp_state_e st;
  logic [7:0] port_data;
  logic [7:0] device_control;
  logic [4:0] extended_control;
  logic tmo_flag;
  logic [2:0] mode;
  logic req;
  logic epp_req;
  logic cyc_write;
  logic cyc_addr;
  logic [7:0] cyc_data;
  logic [10:0] wdog_cnt;
  logic [10:0] stb_age;
  logic tmo_hit;
  logic hs_done;
  logic fifo_push;
  logic fifo_pop;
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] fifo_cnt;
  logic fifo_full;
  logic fifo_empty;
  logic [7:0] fifo_head;
  logic fifo_win;
  logic afifo_win;

  assign mode = extended_control[4:2];
  assign req = (io_rd_i | io_wr_i) && st == PP_ST_IDLE;
  assign epp_req = req && mode == PP_MODE_EPP &&
                   (io_addr_i == PP_OFF_EPP_ADDR || io_addr_i == PP_OFF_EPP_DATA);
  assign fifo_win = io_addr_i == PP_OFF_FIFO &&
                    (mode == PP_MODE_COMPAT || mode == PP_MODE_ECP || mode == PP_MODE_TEST);
  assign afifo_win = io_addr_i == PP_OFF_EPP_ADDR && mode == PP_MODE_ECP;
  assign fifo_full = fifo_cnt == (AW+1)'(FIFO_DEPTH);
  assign fifo_empty = fifo_cnt == '0;
  assign tmo_hit = st == PP_ST_STROBE && wdog_cnt == PP_WDOG_CYC;
  assign hs_done = st == PP_ST_STROBE && hs_f;

  // Data and control stay reachable in every mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_data <= PP_DATA_RST;
      device_control <= PP_CTRL_RST;
      extended_control <= PP_XCTRL_RST;
    end else if (req && io_wr_i && !epp_req) begin
      // Host is stalled during a cycle, so direction only moves in idle
      case (io_addr_i)
        PP_OFF_DATA: port_data <= io_wdata_i;
        PP_OFF_CTRL: device_control <= io_wdata_i;
        PP_OFF_XCTRL: extended_control <= io_wdata_i[7:3];
        default: ;
      endcase
    end
  end

  // Timeout flag: set wins over the read-to-clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmo_flag <= 1'b0;
    end else if (tmo_hit) begin
      tmo_flag <= 1'b1;
    end else if (req && io_rd_i && io_addr_i == PP_OFF_STAT) begin
      tmo_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // EPP cycle engine
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= PP_ST_IDLE;
    end else begin
      case (st)
        PP_ST_IDLE: if (epp_req) st <= PP_ST_STROBE; else if (req) st <= PP_ST_ACK;
        // Hold the host while the peripheral keeps handshake low
        PP_ST_STROBE: if (hs_f || tmo_hit) st <= PP_ST_ACK;
        PP_ST_ACK: st <= PP_ST_IDLE;
        default: st <= PP_ST_IDLE;
      endcase
    end
  end

  // Cycle attributes latched at the start and held to the end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cyc_write <= 1'b0;
      cyc_addr <= 1'b0;
      cyc_data <= '0;
    end else if (epp_req) begin
      cyc_write <= io_wr_i;
      cyc_addr <= io_addr_i == PP_OFF_EPP_ADDR;
      cyc_data <= io_wdata_i;
    end
  end

  // Watchdog counts from the first strobe cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdog_cnt <= '0;
    end else if (st == PP_ST_STROBE && !tmo_hit) begin
      wdog_cnt <= wdog_cnt + 11'h001;
    end else begin
      wdog_cnt <= '0;
    end
  end

  // Independent strobe age, so the bound check does not lean on the watchdog
  always_ff @(posedge clk_i) begin
    if (rst_i || st != PP_ST_STROBE) stb_age <= '0;
    else stb_age <= stb_age + 11'h001;
  end

  // Strobes assert on cycle start, release as the final ready goes out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_phase_strobe_n_o <= 1'b1;
      address_phase_strobe_n_o <= 1'b1;
    end else if (epp_req) begin
      data_phase_strobe_n_o <= io_addr_i == PP_OFF_EPP_ADDR;
      address_phase_strobe_n_o <= io_addr_i != PP_OFF_EPP_ADDR;
    end else if (hs_done || tmo_hit) begin
      data_phase_strobe_n_o <= 1'b1;
      address_phase_strobe_n_o <= 1'b1;
    end
  end

  // Write line: cycle direction, but the control strobe bit may force it
  always_comb begin
    if (st == PP_ST_STROBE || st == PP_ST_ACK) begin
      write_indication_line_n_o = ~cyc_write & ~device_control[PP_CTRL_STROBE];
    end else begin
      write_indication_line_n_o = device_control[PP_CTRL_DIR];
    end
  end

  // Bus floats for reads so the peripheral may drive it
  always_comb begin
    if (st == PP_ST_STROBE || st == PP_ST_ACK) begin
      pd_oe_o = cyc_write;
      pd_o = cyc_data;
    end else begin
      pd_oe_o = ~device_control[PP_CTRL_DIR];
      pd_o = port_data;
    end
  end

  // Reset line follows the control register init bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peripheral_reset_out_n_o <= 1'b0;
    end else begin
      peripheral_reset_out_n_o <= device_control[PP_CTRL_NINIT];
    end
  end

  // No-more-wait pulse to the host ends every access
  assign io_ready_o = st == PP_ST_ACK;

  // ****************************************************************
  // Shared byte FIFO, one buffer behind every FIFO window
  // ****************************************************************
  assign fifo_push = req && io_wr_i && (fifo_win || afifo_win) && !fifo_full;
  assign fifo_pop = req && io_rd_i && fifo_win && !fifo_empty;

  // Pointers and count; a write into a full buffer is dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_cnt <= '0;
    end else begin
      if (fifo_push) wr_ptr <= wr_ptr + AW'(1);
      if (fifo_pop) rd_ptr <= rd_ptr + AW'(1);
      fifo_cnt <= fifo_cnt + (AW+1)'(fifo_push) - (AW+1)'(fifo_pop);
    end
  end

  pp_fifo_mem #(.W(PP_PWORD), .D(FIFO_DEPTH), .AW(AW)) u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(fifo_push),
    .wr_addr_i(wr_ptr),
    .wr_data_i(io_wdata_i),
    .rd_addr_i(rd_ptr),
    .rd_data_o(fifo_head)
  );

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_rdata_o <= '0;
    end else if (hs_done || tmo_hit) begin
      io_rdata_o <= cyc_write ? cyc_data : pd_f;
    end else if (req && io_rd_i && !epp_req) begin
      case (io_addr_i)
        PP_OFF_DATA: io_rdata_o <= device_control[PP_CTRL_DIR] ? pd_f : port_data;
        PP_OFF_STAT: io_rdata_o <= {hs_f, stat_f, 2'b00, tmo_flag};
        PP_OFF_CTRL: io_rdata_o <= {2'b00, device_control[5:0]};
        PP_OFF_FIFO: io_rdata_o <= mode == PP_MODE_CFG ? PP_CFGA_VAL : fifo_head;
        PP_OFF_CFGB: io_rdata_o <= {1'b0, int_f, cfg_irq_sel_i, cfg_dma_sel_i};
        PP_OFF_XCTRL: io_rdata_o <= {extended_control, 1'b0, fifo_full, fifo_empty};
        PP_OFF_CFGA: io_rdata_o <= PP_CFGA_VAL;
        default: io_rdata_o <= '0;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  wait_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st == PP_ST_STROBE && !hs_f && !tmo_hit |=> !io_ready_o)
    else $error("host released while handshake low");
  strobe_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    epp_req |=> (data_phase_strobe_n_o ^ address_phase_strobe_n_o) &&
      address_phase_strobe_n_o == !cyc_addr)
    else $error("no single strobe at cycle start");
  wait_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st == PP_ST_STROBE |-> stb_age <= PP_WDOG_CYC)
    else $error("cycle not ended by watchdog");
  term_strobe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(st == PP_ST_STROBE) |-> io_ready_o && data_phase_strobe_n_o &&
      address_phase_strobe_n_o)
    else $error("strobe held at termination");
  dir_stable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st == PP_ST_STROBE |=> $stable(cyc_write) && $stable(device_control))
    else $error("direction changed inside a cycle");
  read_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st == PP_ST_STROBE && !cyc_write && !device_control[PP_CTRL_STROBE] |->
      write_indication_line_n_o && !pd_oe_o)
    else $error("read cycle drives bus or write line");
  irq_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    peripheral_irq_edge_o |-> peripheral_irq_o ##1 !peripheral_irq_edge_o)
    else $error("interrupt edge malformed");
  reset_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !device_control[PP_CTRL_NINIT] |=> !peripheral_reset_out_n_o)
    else $error("peripheral reset not driven");
  fifo_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fifo_full |-> fifo_cnt == (AW+1)'(FIFO_DEPTH) && !fifo_push)
    else $error("shared buffer overfilled");
  wdog_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tmo_hit |=> tmo_flag && io_ready_o && wdog_cnt == '0)
    else $error("timeout not reported");
  read_byte_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hs_done && !cyc_write |=> io_rdata_o == $past(pd_f))
    else $error("read byte not captured at release");
endmodule // pp_port

/* tb/pp_periph_model.sv */
// Behavioural peripheral on the far side of the parallel port.
// Assumes strobes and write line come straight from the port under test.
`timescale 1ns/1ns
module pp_periph_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Lines from the port
  input wire logic [7:0] pd_i,
  input wire logic data_stb_n_i,
  input wire logic addr_stb_n_i,
  input wire logic write_n_i,
  // Scenario controls; a delay of all ones never releases
  input wire logic [7:0] reply_i,
  input wire logic [15:0] delay_i,
  // Lines back to the port, and the latched write byte for the bench
  output logic [7:0] pd_o,
  output logic handshake_o,
  output logic [7:0] latched_o
);
  // ****************************************************************
  // Cycle tracking
  // ****************************************************************
  logic [15:0] cnt;
  logic driving;
  logic active;

  assign active = !data_stb_n_i || !addr_stb_n_i;

  // Idle: handshake low means ready for the next transfer
  always_ff @(posedge clk_i) begin
    if (rst_i || !active) begin
      cnt <= 16'h0000;
      driving <= 1'b0;
      handshake_o <= 1'b0;
    end else begin
      cnt <= cnt + 16'h0001;
      driving <= write_n_i;
      if (cnt == delay_i && delay_i != 16'hFFFF) begin
        handshake_o <= 1'b1;
      end
    end
  end

  // Write byte is taken when the handshake is released
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latched_o <= 8'h00;
    end else if (active && !write_n_i && cnt == delay_i) begin
      latched_o <= pd_i;
    end
  end

  // Released bus shows the inverse so a stale byte never reads as valid
  assign pd_o = driving ? reply_i : ~reply_i;
endmodule // pp_periph_model

/* tb/tb_pp_port.sv */
// Self-checking bench for the parallel port: host I/O tasks and sequences.
// Assumes the peripheral model beside it and host requests driven at falling edges.
`timescale 1ns/1ns
module tb_pp_port;
  import pp_pkg::*;
  // ****************************************************************
  // Stimulus and wiring
  // ****************************************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] io_addr_i = 4'h0;
  logic io_rd_i = 1'b0;
  logic io_wr_i = 1'b0;
  logic [7:0] io_wdata_i = 8'h00;
  logic [2:0] cfg_irq_sel_i = 3'h5;
  logic [2:0] cfg_dma_sel_i = 3'h3;
  logic irq_in = 1'b0;
  logic [7:0] reply = 8'h00;
  logic [15:0] delay = 16'h0008;
  logic [7:0] io_rdata_o, pd_o, pd_i, m_pd, latched, rd_val;
  logic io_ready_o, pd_oe_o, hs, wl_n, dstb_n, astb_n, prst_n, irq_o, irq_edge;
  logic [7:0] stb_rdy;
  int err_count = 0;
  int samples_checked = 0;
  int dstb_cnt = 0;
  int astb_cnt = 0;
  int wl_cnt = 0;
  int edge_cnt = 0;
  int cyc;

  always #5 clk_i = ~clk_i;
  // Whoever enables its driver owns the data lines
  assign pd_i = pd_oe_o ? pd_o : m_pd;

  pp_port i_pp_port (.clk_i(clk_i), .rst_i(rst_i), .io_addr_i(io_addr_i),
    .io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o), .io_ready_o(io_ready_o), .cfg_irq_sel_i(cfg_irq_sel_i),
    .cfg_dma_sel_i(cfg_dma_sel_i), .pd_i(pd_i), .pd_o(pd_o), .pd_oe_o(pd_oe_o),
    .peripheral_handshake_i(hs), .peripheral_interrupt_in_i(irq_in), .ack_n_i(1'b1),
    .perror_i(1'b0), .select_i(1'b1), .fault_n_i(1'b1), .write_indication_line_n_o(wl_n),
    .data_phase_strobe_n_o(dstb_n), .address_phase_strobe_n_o(astb_n),
    .peripheral_reset_out_n_o(prst_n), .peripheral_irq_o(irq_o),
    .peripheral_irq_edge_o(irq_edge));

  pp_periph_model i_pp_periph_model (.clk_i(clk_i), .rst_i(rst_i), .pd_i(pd_o),
    .data_stb_n_i(dstb_n), .addr_stb_n_i(astb_n), .write_n_i(wl_n), .reply_i(reply),
    .delay_i(delay), .pd_o(m_pd), .handshake_o(hs), .latched_o(latched));

  // ****************************************************************
  // Checking and host access tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Request held until ready is seen, dropped one falling edge later
  task automatic io_op(input logic wr, input logic [3:0] a, input logic [7:0] d,
                       output logic [7:0] rdata, output int n);
    @(negedge clk_i);
    n = 0;
    io_addr_i = a;
    io_wdata_i = d;
    io_rd_i = !wr;
    io_wr_i = wr;
    do begin
      @(negedge clk_i);
      n++;
    end while (io_ready_o !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      err_count++;
      $display("CHECK FAILED at %0t: host cycle never answered", $time);
      tally_and_finish();
    end
    rdata = io_rdata_o;
    stb_rdy = {6'h00, astb_n, dstb_n};
    @(negedge clk_i);
    io_rd_i = 1'b0;
    io_wr_i = 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] v;
    int c;
    io_op(1'b1, a, d, v, c);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    int c;
    io_op(1'b0, a, 8'h00, v, c);
    chk(v, exp);
  endtask

  // Pin monitor; the data bus must stay released through a read strobe
  always @(posedge clk_i) begin
    if (!dstb_n) dstb_cnt++;
    if (!astb_n) astb_cnt++;
    if ((!dstb_n || !astb_n) && !wl_n) wl_cnt++;
    if (irq_edge === 1'b1) edge_cnt++;
    if (!rst_i && (!dstb_n || !astb_n) && wl_n === 1'b1) chk({7'h00, pd_oe_o}, 8'h00);
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (5) @(negedge clk_i);
    chk({7'h00, prst_n}, 8'h00);
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (6) @(negedge clk_i);
    chk({7'h00, prst_n}, 8'h01);
    rd_chk(PP_OFF_CTRL, PP_CTRL_RST);
    rd_chk(PP_OFF_STAT, 8'h58);
    rd_chk(PP_OFF_CFGA, PP_CFGA_VAL);
    wr(PP_OFF_CFGA, 8'hFF);
    rd_chk(PP_OFF_CFGA, PP_CFGA_VAL);
    rd_chk(4'h5, 8'h00);
    rd_chk(PP_OFF_CFGB, 8'h2B);
    cfg_irq_sel_i = 3'h2;
    cfg_dma_sel_i = 3'h6;
    rd_chk(PP_OFF_CFGB, 8'h16);
    // Reset output follows the control register
    wr(PP_OFF_CTRL, 8'h00);
    repeat (2) @(negedge clk_i);
    chk({7'h00, prst_n}, 8'h00);
    wr(PP_OFF_CTRL, 8'h04);
    // Interrupt passes through uninverted with one edge pulse
    edge_cnt = 0;
    irq_in = 1'b1;
    repeat (8) @(negedge clk_i);
    chk({7'h00, irq_o}, 8'h01);
    chk(8'(edge_cnt), 8'h01);
    rd_chk(PP_OFF_CFGB, 8'h56);
    // Common registers stay reachable in every mode
    for (int i = 0; i < 7; i++) begin
      logic [2:0] m;
      m = (i < 5) ? 3'(i) : 3'(i + 1);
      wr(PP_OFF_XCTRL, {m, PP_XCTRL_RST});
      wr(PP_OFF_DATA, 8'h30 + 8'(i));
      rd_chk(PP_OFF_DATA, 8'h30 + 8'(i));
      rd_chk(PP_OFF_CTRL, 8'h04);
      rd_chk(PP_OFF_STAT, 8'h58);
    end
    // Shared FIFO: fill past full, then drain in order
    wr(PP_OFF_XCTRL, {PP_MODE_TEST, PP_XCTRL_RST});
    rd_chk(PP_OFF_XCTRL, 8'hC1);
    for (int i = 0; i < 17; i++) wr(PP_OFF_FIFO, 8'(i * 17 + 1));
    rd_chk(PP_OFF_XCTRL, 8'hC2);
    for (int i = 0; i < 16; i++) rd_chk(PP_OFF_FIFO, 8'(i * 17 + 1));
    rd_chk(PP_OFF_XCTRL, 8'hC1);
    // EPP reads, data and address, short and long peripheral waits
    wr(PP_OFF_XCTRL, {PP_MODE_EPP, PP_XCTRL_RST});
    wr(PP_OFF_CTRL, 8'h24);
    for (int k = 0; k < 4; k++) begin
      int sel;
      int oth;
      reply = 8'hA5 ^ 8'(k * 60);
      delay = 16'(6 + k * 25);
      dstb_cnt = 0;
      astb_cnt = 0;
      io_op(1'b0, k[0] ? PP_OFF_EPP_ADDR : PP_OFF_EPP_DATA, 8'h00, rd_val, cyc);
      sel = k[0] ? astb_cnt : dstb_cnt;
      oth = k[0] ? dstb_cnt : astb_cnt;
      chk(rd_val, reply);
      chk(8'(cyc > delay && sel >= delay), 8'h01);
      chk(8'(oth), 8'h00);
      chk(stb_rdy, 8'h03);
      // Stale handshake must leave the pin filter before the next strobe
      repeat (8) @(negedge clk_i);
    end
    // Control strobe bit may override only the write line during a cycle
    wr(PP_OFF_CTRL, 8'h25);
    wl_cnt = 0;
    io_op(1'b0, PP_OFF_EPP_DATA, 8'h00, rd_val, cyc);
    chk(8'(wl_cnt > 0), 8'h01);
    chk(stb_rdy, 8'h03);
    wr(PP_OFF_CTRL, 8'h24);
    repeat (8) @(negedge clk_i);
    // Peripheral never releases: watchdog ends the cycle
    delay = 16'hFFFF;
    io_op(1'b0, PP_OFF_EPP_DATA, 8'h00, rd_val, cyc);
    chk(8'(cyc >= 1000 && cyc <= 1010), 8'h01);
    rd_chk(PP_OFF_STAT, 8'h59);
    rd_chk(PP_OFF_STAT, 8'h58);
    // EPP write with the direction bit low
    wr(PP_OFF_CTRL, 8'h04);
    delay = 16'h0008;
    wl_cnt = 0;
    wr(PP_OFF_EPP_DATA, 8'h5A);
    chk(latched, 8'h5A);
    chk(8'(wl_cnt > 0), 8'h01);
    chk({6'h00, astb_n, dstb_n}, 8'h03);
    tally_and_finish();
  end
endmodule // tb_pp_port
